// ### sim/fieldbus_process_data_image_test.sv
`timescale 1ns/1ps
`default_nettype none

module fieldbus_process_data_image_test;
	import process_image_pkg::*;
	logic           clk_sys_i = 1'h0;
	logic           resetn_i  = 1'h0;
	logic           bump      = 1'h0;
	logic           ext_en    = 1'h0;
	logic           cont      = 1'h0;
	logic [3:0]     tsk       = 4'h0;
	logic [3:0]     sw        = 4'h0;
	logic [15:0]    win       = 16'h0000;
	logic [1:0]     dly       = 2'h0;
	logic [2:0]     mod_sel   = 3'h2;
	sensor_status_t status    = '0;
	logic [31:0]    rnd       = 32'h0000D842;
	logic [7:0]     trig, tsel;
	logic           mdone, mstart, busy;
	logic [3:0]     act, exp_sw, exp_task;
	logic [5:0]     len;
	logic [15:0]    exp_win;
	logic [19:0]    exp_q [$];
	input_image_t   img;
	logic [5:0]     lens [8] = '{6'h04, 6'h04, 6'h06, 6'h10, 6'h18, 6'h26, 6'h04, 6'h04};
	int             num_errors, cmp_count, exp_cnt, n, cycles;

	master_model far (.clk_sys_i, .bump_i(bump), .task_i(tsk), .delay_i(dly),
		.measure_start_i(mstart), .trigger_request_byte_o(trig),
		.task_select_field_o(tsel), .measure_done_o(mdone));
	process_data_image #(.CHANGE_CYCLES(20), .PERIOD_CYCLES(8)) dut (.clk_sys_i, .resetn_i,
		.task_select_field_i(tsel), .ext_task_select_en_i(ext_en),
		.trigger_request_byte_i(trig), .continuous_measure_mode_i(cont),
		.measure_done_i(mdone), .virtual_switch_outputs_i(sw), .window_results_i(win),
		.status_i(status), .module_select_i(mod_sel), .measure_start_o(mstart),
		.changeover_busy_o(busy), .active_task_o(act), .image_length_o(len), .image_o(img));

	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wait_for(input logic lvl);
		n = 0;
		while (busy !== lvl && n < 40) begin
			tick(1);
			n++;
		end
	endtask

	// A refused trigger must leave counter, switches and windows untouched.
	task automatic meas(input logic go, input logic twice);
		logic [15:0] seen_cnt;
		seen_cnt = img.measurement_counter;
		rnd = lfsr(rnd);
		{dly, win, sw} = rnd[21:0];
		bump = 1'h1;
		tick(1);
		bump = 1'h0;
		n = 0;
		while (mstart !== 1'h1 && n < 6) begin
			tick(1);
			n++;
		end
		check("start", mstart, go);
		if (go) begin
			exp_q.push_back({sw, win});
		end
		if (twice) begin
			bump = 1'h1;
			tick(1);
			bump = 1'h0;
		end
		tick(9);
		if (go) begin
			exp_cnt++;
		end
		if (exp_q.size() != 0) begin
			{exp_sw, exp_win} = exp_q.pop_front();
		end
		check("fresh data", img.measurement_counter != seen_cnt, go);
		check("counter", img.measurement_counter, 16'(exp_cnt));
		check("info", img.output_and_task_info, {exp_sw, exp_task});
		check("windows", img.window_result_bits, exp_win);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			close_out();
		end
	end

	initial begin
		{exp_sw, exp_task, exp_win} = '0;
		tick(12);
		check("reset image", img, 48'h0);
		resetn_i = 1'h1;
		tick(4);
		for (int i = 0; i < 6; i++) begin
			meas(1'h1, i[0]);
		end
		$display("trigger test done");
		for (int m = 0; m < 8; m++) begin
			mod_sel = m[2:0];
			tick(2);
			check("length", len, lens[m]);
			check("window word", img.window_result_bits,
				(lens[m] == 6'h04) ? 16'h0000 : exp_win);
		end
		mod_sel = 3'h2;
		for (int b = 0; b < 7; b++) begin
			status = sensor_status_t'(7'h01 << b);
			tick(2);
			check("flags", img.operating_condition_flags,
				{status[6:4], ~|status[6:4], status[3:0]});
			meas(b < 4, 1'h0);
		end
		status = '0;
		$display("module and state test done");
		cont = 1'h1;
		n = 0;
		for (int k = 0; k < 64; k++) begin
			tick(1);
			n += int'(mstart);
			bump = (k < 40) ? ~bump : 1'h0;
		end
		cont = 1'h0;
		tick(1);
		exp_cnt += n + int'(mstart);
		tick(10);
		check("free run starts", n >= 7, 1'h1);
		check("free run count", img.measurement_counter, 16'(exp_cnt));
		$display("free run test done");
		tsk = 4'h5;
		tick(4);
		check("disabled change", busy, 1'h0);
		ext_en = 1'h1;
		wait_for(1'h1);
		bump = 1'h1;
		tsk = 4'h9;
		tick(1);
		bump = 1'h0;
		wait_for(1'h0);
		check("busy length", n + 1, 21);
		check("task", act, 4'h5);
		check("frozen count", img.measurement_counter, 16'(exp_cnt));
		wait_for(1'h1);
		wait_for(1'h0);
		exp_task = 4'h9;
		check("second task", act, exp_task);
		meas(1'h1, 1'h0);
		$display("task change test done");
		close_out();
	end
endmodule
`default_nettype wire

// ### sim/image_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module image_checker #(
	parameter int CHANGE_CYCLES = 20
) (
	input wire logic                              clk_sys_i,
	input wire logic                              resetn_i,
	input wire logic [7:0]                        trigger_request_byte_i,
	input wire logic                              continuous_measure_mode_i,
	input wire process_image_pkg::sensor_status_t status_i,
	input wire logic                              measure_start_o,
	input wire logic                              changeover_busy_o,
	input wire logic [3:0]                        active_task_o,
	input wire process_image_pkg::input_image_t   image_o
);
	import process_image_pkg::*;
	logic [2:0]  live_q;
	logic [15:0] busy_q;
	logic [7:0]  flags_q;
	logic        ok;
	logic        halt;
	logic [15:0] cnt;
	assign ok = live_q[2];
	assign halt = status_i.command_mode | status_i.keypad_mode;
	assign cnt = image_o.measurement_counter;

	// -------------------------------------------------------------
	// Helper logic
	// -------------------------------------------------------------
	// The design's own reset lags the pin by two edges, so checks wait for it.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			live_q  <= 3'h0;
			busy_q  <= 16'h0000;
			flags_q <= 8'h00;
		end else begin
			live_q  <= {live_q[1:0], 1'h1};
			busy_q  <= changeover_busy_o ? busy_q + 16'h0001 : 16'h0000;
			flags_q <= {status_i[6:4], ~|status_i[6:4], status_i[3:0]};
		end
	end

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	property p_start_gap; measure_start_o |=> !measure_start_o [*7]; endproperty
	a_start_gap: assert property (p_start_gap) else $error("starts too close");
	property p_start_cause; ok && measure_start_o |-> $past(continuous_measure_mode_i)
		|| $past(trigger_request_byte_i) != $past(trigger_request_byte_i, 2); endproperty
	a_start_cause: assert property (p_start_cause) else $error("start without cause");
	property p_count_step; ok && $changed(cnt) |-> cnt == $past(cnt) + 16'h0001; endproperty
	a_count_step: assert property (p_count_step) else $error("counter step");
	property p_frozen; ok && changeover_busy_o && $past(changeover_busy_o) |-> $stable(image_o);
	endproperty
	a_frozen: assert property (p_frozen) else $error("image moved in changeover");
	property p_busy_len; ok && $fell(changeover_busy_o) |-> int'(busy_q) == CHANGE_CYCLES + 1;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("changeover length");
	property p_halt; ok && halt && $past(halt) && $past(halt, 2) |-> $stable(cnt); endproperty
	a_halt: assert property (p_halt) else $error("counter moved while halted");
	property p_flags; ok && !changeover_busy_o && !$past(changeover_busy_o)
		|-> image_o.operating_condition_flags == flags_q; endproperty
	a_flags: assert property (p_flags)
		else $error("state byte");
	property p_task; ok |-> image_o.output_and_task_info[3:0] == active_task_o
		&& (!$changed(active_task_o) || $fell(changeover_busy_o)); endproperty
	a_task: assert property (p_task) else $error("task nibble");

	cover property ($fell(changeover_busy_o));
	cover property (measure_start_o && continuous_measure_mode_i);
	cover property (halt ##1 halt);
endmodule

bind process_data_image image_checker #(.CHANGE_CYCLES(CHANGE_CYCLES)) u_chk (
	.clk_sys_i, .resetn_i, .trigger_request_byte_i, .continuous_measure_mode_i,
	.status_i, .measure_start_o, .changeover_busy_o, .active_task_o, .image_o);
`default_nettype wire

// ### sim/master_model.sv
`timescale 1ns/1ps
`default_nettype none

module master_model (
	input  wire logic       clk_sys_i,
	input  wire logic       bump_i,
	input  wire logic [3:0] task_i,
	input  wire logic [1:0] delay_i,
	input  wire logic       measure_start_i,
	output logic [7:0]      trigger_request_byte_o,
	output logic [7:0]      task_select_field_o,
	output logic            measure_done_o
);
	int wait_q = -1;

	initial begin
		trigger_request_byte_o = 8'h00;
		task_select_field_o    = 8'h00;
		measure_done_o         = 1'h0;
	end

	// The sensor core answers each start after a short variable delay.
	always @(posedge clk_sys_i) begin
		measure_done_o      <= #1 (wait_q == 0);
		task_select_field_o <= #1 {4'h0, task_i};
		if (bump_i) begin
			trigger_request_byte_o <= #1 trigger_request_byte_o + 8'h01;
		end
		if (measure_start_i) begin
			wait_q = int'(delay_i);
		end else if (wait_q >= 0) begin
			wait_q = wait_q - 1;
		end
	end
endmodule
`default_nettype wire

// ### verilog/interval_timer.sv
`timescale 1ns/1ps
`default_nettype none

module interval_timer (
	input  wire logic                                clk_sys_i,
	input  wire logic                                rst_n_i,
	input  wire logic                                load_i,
	input  wire logic [process_image_pkg::TIMER_W-1:0] cycles_i,
	output logic                                     busy_o,
	output logic                                     done_o
);
	import process_image_pkg::*;

	typedef struct packed {
		logic [TIMER_W-1:0] count;
		logic               busy;
		logic               done;
	} timer_state_t;

	timer_state_t s_d;
	timer_state_t s_q;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (load_i) begin
			s_d.count = cycles_i;
			s_d.busy  = 1'b1;
		end else if (s_q.busy) begin
			// The last counted cycle ends the interval, so a load of N spans N cycles.
			if (s_q.count <= TIMER_W'(1)) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end else begin
				s_d.count = s_q.count - TIMER_W'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy_o = s_q.busy;
	assign done_o = s_q.done;

endmodule

`default_nettype wire

// ### verilog/process_data_image.sv
`timescale 1ns/1ps
`default_nettype none

module process_data_image #(
	parameter int CHANGE_CYCLES = process_image_pkg::CHANGEOVER_CYC,
	parameter int PERIOD_CYCLES = process_image_pkg::MEAS_PERIOD_CYC
) (
	input  wire logic                             clk_sys_i,
	input  wire logic                             resetn_i,
	input  wire logic [7:0]                       task_select_field_i,
	input  wire logic                             ext_task_select_en_i,
	input  wire logic [7:0]                       trigger_request_byte_i,
	input  wire logic                             continuous_measure_mode_i,
	input  wire logic                             measure_done_i,
	input  wire logic [3:0]                       virtual_switch_outputs_i,
	input  wire logic [15:0]                      window_results_i,
	input  wire process_image_pkg::sensor_status_t status_i,
	input  wire logic [2:0]                       module_select_i,
	output logic                                  measure_start_o,
	output logic                                  changeover_busy_o,
	output logic [3:0]                            active_task_o,
	output logic [5:0]                            image_length_o,
	output process_image_pkg::input_image_t       image_o
);
	import process_image_pkg::*;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		meas_state_t    meas;
		logic           primed;
		logic [7:0]     trig_prev;
		logic           changing;
		logic [3:0]     pending_task;
		logic [3:0]     active_task;
		logic [3:0]     switches;
		logic [15:0]    windows;
		logic [15:0]    win_out;
		logic [15:0]    counter;
		logic [7:0]     flags;
		logic           start;
		logic [5:0]     length;
	} image_state_t;

	image_state_t s_d;
	image_state_t s_q;

	logic change_load;
	logic change_busy;
	logic change_done;
	logic rate_load;
	logic rate_busy;

	localparam logic [TIMER_W-1:0] CHANGE_LOAD = TIMER_W'(CHANGE_CYCLES);
	localparam logic [TIMER_W-1:0] PERIOD_LOAD = TIMER_W'(PERIOD_CYCLES);

	interval_timer u_change_timer (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n),
		.load_i    (change_load),
		.cycles_i  (CHANGE_LOAD),
		.busy_o    (change_busy),
		.done_o    (change_done)
	);

	// Spacing between measurement starts keeps the detection rate at the bus maximum.
	interval_timer u_rate_timer (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n),
		.load_i    (rate_load),
		.cycles_i  (PERIOD_LOAD),
		.busy_o    (rate_busy),
		.done_o    ()
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic       trig_change;
	logic       halted;
	logic       may_start;
	logic [3:0] req_task;

	always_comb begin
		s_d         = s_q;
		s_d.start   = 1'b0;
		change_load = 1'b0;
		rate_load   = 1'b0;
		req_task    = task_select_field_i[3:0];

		// Trigger byte is tracked every cycle so a change seen while busy is dropped.
		trig_change   = s_q.primed && (trigger_request_byte_i != s_q.trig_prev);
		s_d.trig_prev = trigger_request_byte_i;
		s_d.primed    = 1'b1;

		// Command and keypad modes ignore the master and hold the data.
		halted = status_i.command_mode || status_i.keypad_mode
			|| status_i.fault_mode || s_q.changing;

		// Task changeover.
		if (!s_q.changing && ext_task_select_en_i && (req_task != s_q.active_task)
			&& !status_i.command_mode && !status_i.keypad_mode) begin
			s_d.changing     = 1'b1;
			s_d.pending_task = req_task;
			change_load      = 1'b1;
		end
		if (s_q.changing && change_done) begin
			s_d.changing    = 1'b0;
			s_d.active_task = s_q.pending_task;
		end

		// Measurement sequencing.
		may_start = !halted && !rate_busy && !change_busy;
		case (s_q.meas)
			MEAS_IDLE: begin
				if (may_start && continuous_measure_mode_i) begin
					s_d.start = 1'b1;
					s_d.meas  = MEAS_BUSY;
					rate_load = 1'b1;
				end else if (may_start && trig_change) begin
					s_d.start = 1'b1;
					s_d.meas  = MEAS_BUSY;
					rate_load = 1'b1;
				end
			end
			MEAS_BUSY: begin
				if (s_q.changing) begin
					// A measurement cut by a task change is discarded uncounted.
					s_d.meas = MEAS_IDLE;
				end else if (measure_done_i) begin
					s_d.meas = MEAS_IDLE;
					if (!halted) begin
						s_d.counter  = s_q.counter + COUNTER_STEP;
						s_d.switches = virtual_switch_outputs_i;
						s_d.windows  = window_results_i;
					end
				end
			end
			default: begin
				s_d.meas = MEAS_IDLE;
			end
		endcase

		// Status flags are held during a changeover like the rest of the image.
		if (!s_q.changing) begin
			s_d.flags                   = BYTE_RESET;
			s_d.flags[STATE_FAULT_MODE] = status_i.fault_mode;
			s_d.flags[STATE_COMMAND]    = status_i.command_mode;
			s_d.flags[STATE_KEYPAD]     = status_i.keypad_mode;
			s_d.flags[STATE_DETECT]     = !status_i.fault_mode
				&& !status_i.command_mode && !status_i.keypad_mode;
			s_d.flags[STATE_FAULT]      = status_i.fault;
			s_d.flags[STATE_TEMP_FAULT] = status_i.temp_fault;
			s_d.flags[STATE_ACTIVATED]  = status_i.activated;
			s_d.flags[STATE_ETH_LINK]   = status_i.eth_link;
		end

		// Image length grows with the module number from 1 to 5; any other number gives the base length.
		if (module_select_i == MODULE_BASE) begin
			s_d.length = LEN_BASE;
		end else if (module_select_i == MODULE_WINDOW) begin
			s_d.length = LEN_WINDOW;
		end else if (module_select_i == MODULE_HITS_A) begin
			s_d.length = LEN_HITS_A;
		end else if (module_select_i == MODULE_HITS_B) begin
			s_d.length = LEN_HITS_B;
		end else if (module_select_i == MODULE_HITS_C) begin
			s_d.length = LEN_HITS_C;
		end else begin
			s_d.length = LEN_BASE;
		end

		// The window word is registered here so the image output stays a plain flop.
		if (s_d.length == LEN_BASE) begin
			s_d.win_out = '0;
		end else begin
			s_d.win_out = s_d.windows;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			s_q              <= '0;
			s_q.meas         <= MEAS_IDLE;
			s_q.active_task  <= TASK_RESET;
			s_q.pending_task <= TASK_RESET;
			s_q.counter      <= COUNTER_RESET;
			s_q.flags        <= BYTE_RESET;
			s_q.length       <= LEN_BASE;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// All image fields are flops; the window word reads zero unless a module carrying it is set.
	assign measure_start_o   = s_q.start;
	assign changeover_busy_o = s_q.changing;
	assign active_task_o     = s_q.active_task;
	assign image_length_o    = s_q.length;

	assign image_o.output_and_task_info      = {s_q.switches, s_q.active_task};
	assign image_o.operating_condition_flags = s_q.flags;
	assign image_o.measurement_counter       = s_q.counter;
	assign image_o.window_result_bits        = s_q.win_out;

endmodule

`default_nettype wire

// ### verilog/process_image_pkg.sv
// Function
// - Master writes a 4-bit task number 0..15 in output byte 2; device adopts it.
// - Task changeover lasts about 70 ms with all input data frozen.
// - After changeover data update again, info byte shows new task, counter resumes.
// - The 16-bit scan counter is presented as high byte then low byte.
// - Counter adds one per completed measurement and holds during a task change.
// - Free-running mode keeps counting measurements without explicit activation.
// - Triggered mode counts only triggers that actually start a measurement.
// - Info byte bits 7..4 carry virtual switching outputs 4..1, 1 means active.
// - Info byte bits 3..0 carry the task number currently in effect.
// - State byte bit 7 is error mode; bit 3 flags a permanent error.
// - State bit 6 is command mode; queries ignored, data and counter frozen.
// - State bit 5 is keypad operation; queries ignored, data and counter frozen.
// - State bit 4 is normal detection operation, the only full-rate state.
// - State bit 2 is a warning for a temporary malfunction.
// - State bit 1 is sensor activated; bit 0 is Ethernet link connected.
// - Higher input modules contain all lower module inputs plus extensions.
// - With either of the two smallest modules the device sustains 100 Hz.
// - Sixteen window results pack into 16 bits, window 16 at bit 15.
// - A change of the master trigger byte starts a measurement.
// - Trigger rate at most 100 Hz; triggers while busy or free-running are ignored.
package process_image_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_FREQ_HZ     = 100_000_000;
	localparam int CHANGEOVER_MS   = 70;
	localparam int CHANGEOVER_CYC  = (CLK_FREQ_HZ / 1000) * CHANGEOVER_MS;
	localparam int MAX_RATE_HZ     = 100;
	localparam int MEAS_PERIOD_CYC = CLK_FREQ_HZ / MAX_RATE_HZ;
	localparam int TIMER_W         = 24;

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int INFO_SWITCH_LSB  = 4;
	localparam int INFO_TASK_LSB    = 0;
	localparam int STATE_FAULT_MODE = 7;
	localparam int STATE_COMMAND    = 6;
	localparam int STATE_KEYPAD     = 5;
	localparam int STATE_DETECT     = 4;
	localparam int STATE_FAULT      = 3;
	localparam int STATE_TEMP_FAULT = 2;
	localparam int STATE_ACTIVATED  = 1;
	localparam int STATE_ETH_LINK   = 0;

	// ------------------------------------------------------------
	// Reset values and image sizes
	// ------------------------------------------------------------
	localparam logic [15:0] COUNTER_RESET = 16'h0000;
	localparam logic [15:0] COUNTER_STEP  = 16'h0001;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;
	localparam logic [3:0]  TASK_RESET    = 4'h0;
	localparam logic [2:0]  MODULE_BASE   = 3'h1;
	localparam logic [2:0]  MODULE_WINDOW = 3'h2;
	localparam logic [2:0]  MODULE_HITS_A = 3'h3;
	localparam logic [2:0]  MODULE_HITS_B = 3'h4;
	localparam logic [2:0]  MODULE_HITS_C = 3'h5;
	localparam logic [5:0]  LEN_BASE      = 6'h04;
	localparam logic [5:0]  LEN_WINDOW    = 6'h06;
	localparam logic [5:0]  LEN_HITS_A    = 6'h10;
	localparam logic [5:0]  LEN_HITS_B    = 6'h18;
	localparam logic [5:0]  LEN_HITS_C    = 6'h26;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic fault_mode;
		logic command_mode;
		logic keypad_mode;
		logic fault;
		logic temp_fault;
		logic activated;
		logic eth_link;
	} sensor_status_t;

	typedef struct packed {
		logic [7:0]  output_and_task_info;
		logic [7:0]  operating_condition_flags;
		logic [15:0] measurement_counter;
		logic [15:0] window_result_bits;
	} input_image_t;

	typedef enum logic [1:0] {
		MEAS_IDLE,
		MEAS_BUSY
	} meas_state_t;

endpackage
